// ==== rtl/lsdr_pkg.sv ====
package lsdr_pkg;
  // Register pointer values on the serial bus
  localparam logic [4:0] REG_ID      = 5'h12;
  localparam logic [4:0] REG_STATUS  = 5'h13;
  localparam logic [4:0] REG_CH0_LO  = 5'h14;
  localparam logic [4:0] REG_CH0_HI  = 5'h15;
  localparam logic [4:0] REG_CH1_LO  = 5'h16;
  localparam logic [4:0] REG_CH1_HI  = 5'h17;
  // Status field positions
  localparam int         ST_NP_BIT    = 5;
  localparam int         ST_LIGHT_BIT = 4;
  localparam int         ST_VALID_BIT = 0;
  // Bus address and identity; the identity value is arbitrary
  localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h29;
  localparam logic [7:0] ID_VALUE_DEFAULT = 8'hA5;
  // Channel layout
  localparam int         NUM_CH = 2;
  localparam int         CNT_W  = 16;
  // Serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Persistence filter: codes up to 3 count one-to-one, then steps of 5
  localparam logic [3:0] PERS_LINEAR_MAX = 4'h3;
  localparam logic [5:0] PERS_STEP       = 6'h05;
  localparam logic [5:0] PERS_CNT_MAX    = 6'h3F;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_WRITE,
    ST_ACK_WR,
    ST_READ,
    ST_ACK_RD
  } lsdr_state_t;
endpackage : lsdr_pkg

// ==== rtl/lsdr_chan.sv ====
`timescale 1ns/1ns
module lsdr_chan
  import lsdr_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         conv_done,
  input  wire logic [W-1:0] count_in,
  input  wire logic         low_rd,
  output logic      [W-1:0] count_ff,
  output logic      [W/2-1:0] shadow_hi_ff
);
  // Live count is double-buffered: it only moves at the end of a conversion
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_ff     <= '0;
      shadow_hi_ff <= '0;
    end else begin
      if (conv_done) begin
        count_ff <= count_in;
      end
      // Old high byte is caught even if a conversion lands this same cycle
      if (low_rd) begin
        shadow_hi_ff <= count_ff[W-1:W/2];
      end
    end
  end
endmodule : lsdr_chan

// ==== rtl/lsdr_top.sv ====
`timescale 1ns/1ns
module lsdr_top
  import lsdr_pkg::*;
#(
  parameter logic [6:0] BUS_ADDR = BUS_ADDR_DEFAULT,
  parameter logic [7:0] ID_VALUE = ID_VALUE_DEFAULT
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  output logic                  irq_pin_out,
  output logic                  irq_pin_oe,
  input  wire logic             conv_done,
  input  wire logic [CNT_W-1:0] ch0_count_in,
  input  wire logic [CNT_W-1:0] ch1_count_in,
  input  wire logic             sensing_enable,
  input  wire logic             light_irq_enable,
  input  wire logic             nopersist_irq_enable,
  input  wire logic [3:0]       persist_sel,
  input  wire logic [CNT_W-1:0] persist_low_thr,
  input  wire logic [CNT_W-1:0] persist_high_thr,
  input  wire logic [CNT_W-1:0] nopersist_low_thr,
  input  wire logic [CNT_W-1:0] nopersist_high_thr,
  input  wire logic             irq_clear
);
  logic              scl_meta_ff, scl_sync_ff, scl_prev_ff;
  logic              sda_meta_ff, sda_sync_ff, sda_prev_ff;
  lsdr_state_t       state_ff;
  logic [3:0]        bit_cnt_ff;
  logic [7:0]        shift_ff;
  logic [7:0]        tx_ff;
  logic [4:0]        ptr_ff;
  logic              rw_ff, first_wr_ff, nack_ff;
  logic              sda_oe_ff, sda_out_ff, irq_oe_ff, irq_out_ff;
  logic              nopersist_irq_flag_ff, light_irq_flag_ff, result_valid_flag_ff;
  logic [5:0]        pers_cnt_ff;
  logic [CNT_W-1:0]  cnt_in    [NUM_CH];
  logic [CNT_W-1:0]  live_cnt  [NUM_CH];
  logic [CNT_W/2-1:0] shadow_hi [NUM_CH];
  logic              low_rd    [NUM_CH];

  // Required consecutive out-of-range count for a filter code
  function automatic logic [5:0] pers_need(input logic [3:0] sel);
    logic [5:0] s;
    s = {2'h0, sel};
    if (sel <= PERS_LINEAR_MAX) begin
      pers_need = s;
    end else begin
      pers_need = 6'((s - {2'h0, PERS_LINEAR_MAX}) * PERS_STEP);
    end
  endfunction : pers_need

  // Bus sampling; first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (reset) begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_meta_ff <= scl_in;
      scl_sync_ff <= scl_meta_ff;
      scl_prev_ff <= scl_sync_ff;
      sda_meta_ff <= sda_in;
      sda_sync_ff <= sda_meta_ff;
      sda_prev_ff <= sda_sync_ff;
    end
  end

  wire scl_rise   = scl_sync_ff & ~scl_prev_ff;
  wire scl_fall   = ~scl_sync_ff & scl_prev_ff;
  wire bus_start  = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
  wire bus_stop   = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;
  wire byte_full  = (bit_cnt_ff == BITS_PER_BYTE);
  wire addr_match = (shift_ff[7:1] == BUS_ADDR);
  wire load_rd    = scl_fall & ((state_ff == ST_ACK_ADDR & rw_ff) | (state_ff == ST_ACK_RD & ~nack_ff));
  wire wr_byte_done = scl_fall & (state_ff == ST_WRITE) & byte_full;
  wire [7:0] status_byte = {2'h0, nopersist_irq_flag_ff, light_irq_flag_ff, 3'h0, result_valid_flag_ff};
  wire [7:0] rd_byte =
    (ptr_ff == REG_ID)     ? ID_VALUE :
    (ptr_ff == REG_STATUS) ? status_byte :
    (ptr_ff == REG_CH0_LO) ? live_cnt[0][CNT_W/2-1:0] :
    (ptr_ff == REG_CH0_HI) ? shadow_hi[0] :
    (ptr_ff == REG_CH1_LO) ? live_cnt[1][CNT_W/2-1:0] :
    (ptr_ff == REG_CH1_HI) ? shadow_hi[1] : 8'h00;
  assign cnt_in[0] = ch0_count_in;
  assign cnt_in[1] = ch1_count_in;
  assign low_rd[0] = load_rd & (ptr_ff == REG_CH0_LO);
  assign low_rd[1] = load_rd & (ptr_ff == REG_CH1_LO);
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
      lsdr_chan #(
        .W (CNT_W)
      ) lsdr_chan_inst (
        .core_clk     (core_clk),
        .reset        (reset),
        .conv_done    (conv_done),
        .count_in     (cnt_in[g]),
        .low_rd       (low_rd[g]),
        .count_ff     (live_cnt[g]),
        .shadow_hi_ff (shadow_hi[g])
      );
    end
  endgenerate
  // Serial target: pointer byte first, then reads auto-increment.
  // Write data after the pointer is acked and dropped: every register here is read only.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_ff    <= ST_IDLE;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= 8'h00;
      tx_ff       <= 8'h00;
      ptr_ff      <= 5'h00;
      rw_ff       <= 1'b0;
      first_wr_ff <= 1'b0;
      nack_ff     <= 1'b0;
      sda_oe_ff   <= 1'b0;
    end else if (bus_start) begin
      state_ff   <= ST_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_oe_ff  <= 1'b0;
    end else if (bus_stop) begin
      state_ff  <= ST_IDLE;
      sda_oe_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          sda_oe_ff <= 1'b0;
        end
        ST_ADDR, ST_WRITE: begin
          if (scl_rise) begin
            shift_ff   <= {shift_ff[6:0], sda_sync_ff};
            bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
          end else if (scl_fall && byte_full) begin
            if (state_ff == ST_ADDR && !addr_match) begin
              state_ff <= ST_IDLE;
            end else begin
              sda_oe_ff <= 1'b1;
              if (state_ff == ST_ADDR) begin
                state_ff <= ST_ACK_ADDR;
                rw_ff    <= shift_ff[0];
              end else begin
                state_ff    <= ST_ACK_WR;
                first_wr_ff <= 1'b0;
                if (first_wr_ff) begin
                  ptr_ff <= shift_ff[4:0];
                end
              end
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_WR: begin
          if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            if (state_ff == ST_ACK_WR || !rw_ff) begin
              sda_oe_ff <= 1'b0;
              state_ff  <= ST_WRITE;
              if (state_ff == ST_ACK_ADDR) begin
                first_wr_ff <= 1'b1;
              end
            end
          end
          if (load_rd) begin
            state_ff   <= ST_READ;
            sda_oe_ff  <= ~rd_byte[7];
            tx_ff      <= {rd_byte[6:0], 1'b0};
            bit_cnt_ff <= 4'h1;
            ptr_ff     <= 5'(ptr_ff + 5'h01);
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (byte_full) begin
              sda_oe_ff <= 1'b0;
              state_ff  <= ST_ACK_RD;
            end else begin
              sda_oe_ff  <= ~tx_ff[7];
              tx_ff      <= {tx_ff[6:0], 1'b0};
              bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
            end
          end
        end
        ST_ACK_RD: begin
          if (scl_rise) begin
            nack_ff <= sda_sync_ff;
          end else if (load_rd) begin
            state_ff   <= ST_READ;
            sda_oe_ff  <= ~rd_byte[7];
            tx_ff      <= {rd_byte[6:0], 1'b0};
            bit_cnt_ff <= 4'h1;
            ptr_ff     <= 5'(ptr_ff + 5'h01);
          end else if (scl_fall) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Channel 0 comparisons use the incoming result of this conversion
  wire ch0_out_pers = (ch0_count_in < persist_low_thr) | (ch0_count_in > persist_high_thr);
  wire ch0_out_np   = (ch0_count_in < nopersist_low_thr) | (ch0_count_in > nopersist_high_thr);
  wire [5:0] need_cnt = pers_need(persist_sel);
  wire [5:0] nxt_pers_cnt = !ch0_out_pers ? 6'h00 :
                            (pers_cnt_ff == PERS_CNT_MAX) ? pers_cnt_ff : 6'(pers_cnt_ff + 6'h01);
  wire pers_hit = (persist_sel == 4'h0) | (ch0_out_pers & (nxt_pers_cnt >= need_cnt));
  wire conv_live = conv_done & sensing_enable;
  // Interrupt flags are cleared only by irq_clear, and a set in the same cycle wins; the valid flag clears while sensing is disabled
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pers_cnt_ff           <= 6'h00;
      light_irq_flag_ff     <= 1'b0;
      nopersist_irq_flag_ff <= 1'b0;
      result_valid_flag_ff  <= 1'b0;
    end else begin
      if (!sensing_enable) begin
        pers_cnt_ff <= 6'h00;
      end else if (conv_done) begin
        pers_cnt_ff <= nxt_pers_cnt;
      end
      light_irq_flag_ff     <= (conv_live & pers_hit) | (light_irq_flag_ff & ~irq_clear);
      nopersist_irq_flag_ff <= (conv_live & ch0_out_np) | (nopersist_irq_flag_ff & ~irq_clear);
      result_valid_flag_ff  <= sensing_enable & (conv_done | result_valid_flag_ff);
    end
  end
  // Open-drain pins: only the enable moves, the driven level is always low
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_oe_ff  <= 1'b0;
      irq_out_ff <= 1'b0;
      sda_out_ff <= 1'b0;
    end else begin
      irq_oe_ff  <= (light_irq_flag_ff & light_irq_enable) | (nopersist_irq_flag_ff & nopersist_irq_enable);
      irq_out_ff <= 1'b0;
      sda_out_ff <= 1'b0;
    end
  end
  assign sda_out     = sda_out_ff;
  assign sda_oe      = sda_oe_ff;
  assign irq_pin_out = irq_out_ff;
  assign irq_pin_oe  = irq_oe_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_id_fixed: assert property ((ptr_ff == REG_ID) |-> rd_byte == ID_VALUE)
    else $error("identity byte wrong");
  chk_status_ro: assert property ((wr_byte_done && !first_wr_ff && ptr_ff == REG_STATUS && !conv_done && !irq_clear
    && sensing_enable) |=> $stable(status_byte))
    else $error("status changed by write");
  chk_np_set: assert property ((conv_done && sensing_enable && ch0_out_np) |=> status_byte[ST_NP_BIT])
    else $error("no-persist flag not set");
  chk_light_pin: assert property ((light_irq_flag_ff && light_irq_enable) |=> irq_pin_oe)
    else $error("interrupt pin not driven");
  chk_pin_quiet: assert property ((!light_irq_enable && !nopersist_irq_enable) |=> !irq_pin_oe)
    else $error("interrupt pin driven while disabled");
  chk_valid_set: assert property ((conv_done && sensing_enable) |=> status_byte[ST_VALID_BIT])
    else $error("valid flag not set");
  chk_valid_clear: assert property (!sensing_enable |=> !status_byte[ST_VALID_BIT])
    else $error("valid flag not cleared");
  chk_rsvd_zero: assert property ((ptr_ff == REG_STATUS) |-> (rd_byte[7:6] == 2'h0 && rd_byte[3:1] == 3'h0))
    else $error("reserved status bits set");
  chk_count_load: assert property (conv_done |=> live_cnt[0] == $past(ch0_count_in))
    else $error("channel count not loaded");
  chk_shadow_latch: assert property (low_rd[0] |=> shadow_hi[0] == $past(live_cnt[0][CNT_W-1:CNT_W/2]))
    else $error("shadow not latched");
  chk_shadow_hold: assert property ((!low_rd[0] && !low_rd[1]) |=> $stable(shadow_hi[0]) && $stable(shadow_hi[1]))
    else $error("shadow moved without low read");
  chk_shadow_map: assert property ((ptr_ff == REG_CH1_HI) |-> rd_byte == shadow_hi[1])
    else $error("high byte not from shadow");
  chk_persist_every: assert property ((conv_done && sensing_enable && persist_sel == 4'h0)
    |=> status_byte[ST_LIGHT_BIT])
    else $error("persist flag missed");
  cov_low_read: cover property (low_rd[0] ##[1:400] low_rd[1]);
  cov_irq_pin: cover property ($rose(irq_pin_oe));
  cov_np_flag: cover property ($rose(nopersist_irq_flag_ff));
endmodule : lsdr_top

// ==== bench/lsdr_host_model.sv ====
`timescale 1ns/1ns
module lsdr_host_model
  import lsdr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       sda_wire,
  output logic            scl,
  output logic            sda_host_oe,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output int              nack_cnt
);
  initial begin
    scl = 1'b1;
    sda_host_oe = 1'b0;
    rd_data = 8'h00;
    rd_valid = 1'b0;
    nack_cnt = 0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask : wt

  // Long low phase: the device answers only after its synchroniser sees the fall
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    wt(2);
    sda_host_oe = ~b;
    wt(4);
    scl = 1'b1;
    wt(2);
    r = sda_wire;
  endtask : bit_io

  // Serves both the first and a repeated start
  task automatic start();
    scl = 1'b0;
    wt(2);
    sda_host_oe = 1'b0;
    wt(4);
    scl = 1'b1;
    wt(2);
    sda_host_oe = 1'b1;
    wt(2);
  endtask : start

  task automatic stop();
    scl = 1'b0;
    wt(2);
    sda_host_oe = 1'b1;
    wt(4);
    scl = 1'b1;
    wt(2);
    sda_host_oe = 1'b0;
    wt(4);
  endtask : stop

  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0) nack_cnt++;
  endtask : wbyte

  task automatic rbyte(input logic ack_it);
    logic       r;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(~ack_it, r);
    rd_data = d;
    rd_valid = 1'b1;
    wt(1);
    rd_valid = 1'b0;
  endtask : rbyte

  // Upper reserved status pair is kept zero by callers
  task automatic write(input logic [7:0] ptr, input logic [7:0] d);
    start();
    wbyte({BUS_ADDR_DEFAULT, 1'b0});
    wbyte(ptr);
    wbyte(d);
    stop();
  endtask : write

  // Whole burst in one frame keeps channel bytes together
  task automatic read(input logic [7:0] ptr, input int n);
    start();
    wbyte({BUS_ADDR_DEFAULT, 1'b0});
    wbyte(ptr);
    start();
    wbyte({BUS_ADDR_DEFAULT, 1'b1});
    for (int i = 0; i < n; i++) rbyte(i < n - 1);
    stop();
  endtask : read
endmodule : lsdr_host_model

// ==== bench/lsdr_top_tb.sv ====
`timescale 1ns/1ns
module lsdr_top_tb;
  import lsdr_pkg::*;
  logic        core_clk, reset, sda_out, sda_oe, irq_pin_out, irq_pin_oe, conv_done, irq_clear;
  logic        sensing_enable, light_irq_enable, nopersist_irq_enable, scl, sda_host_oe, rd_valid;
  logic [15:0] ch0_count_in, ch1_count_in, persist_low_thr, persist_high_thr;
  logic [15:0] nopersist_low_thr, nopersist_high_thr, a0, a1, b0, b1;
  logic [3:0]  persist_sel;
  logic [7:0]  rd_data;
  logic [7:0]  exp_q[$];
  logic [31:0] rnd = 32'h0000F264;
  int          nack_cnt;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  wire         sda_wire = ~(sda_oe | sda_host_oe);

  lsdr_top lsdr_top_inst(.core_clk, .reset, .scl_in(scl), .sda_in(sda_wire), .sda_out, .sda_oe,
    .irq_pin_out, .irq_pin_oe, .conv_done, .ch0_count_in, .ch1_count_in, .sensing_enable,
    .light_irq_enable, .nopersist_irq_enable, .persist_sel, .persist_low_thr, .persist_high_thr,
    .nopersist_low_thr, .nopersist_high_thr, .irq_clear);
  lsdr_host_model lsdr_host_model_inst(.core_clk, .sda_wire, .scl, .sda_host_oe, .rd_data, .rd_valid,
    .nack_cnt);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (exp !== got) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask : wt

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic rnd16(output logic [15:0] v);
    rnd = lfsr(rnd);
    v = rnd[15:0];
  endtask : rnd16

  task automatic conv(input logic [15:0] c0, input logic [15:0] c1);
    conv_done = 1'b1;
    ch0_count_in = c0;
    ch1_count_in = c1;
    wt(1);
    conv_done = 1'b0;
    wt(3);
  endtask : conv

  task automatic clear_irq();
    irq_clear = 1'b1;
    wt(1);
    irq_clear = 1'b0;
    wt(1);
  endtask : clear_irq

  // Each byte seen on the bus is matched against the oldest expectation
  always @(posedge core_clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected byte", 8'h00, 8'hFF);
      else chk("read byte", exp_q.pop_front(), rd_data);
    end
  end

  // Budget leaves some five times the expected run length
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    {reset, conv_done, irq_clear, sensing_enable} = 4'h9;
    {light_irq_enable, nopersist_irq_enable, persist_sel} = 6'h01;
    {ch0_count_in, ch1_count_in, persist_low_thr} = 48'h0;
    persist_high_thr = 16'hFFFF;
    nopersist_low_thr = 16'h1000;
    nopersist_high_thr = 16'hF000;
    wt(6);
    reset = 1'b0;
    wt(3);
    lsdr_host_model_inst.write(8'h12, 8'h00);
    exp_q.push_back(ID_VALUE_DEFAULT);
    lsdr_host_model_inst.read(8'h12, 1);
    exp_q.push_back(8'h00);
    lsdr_host_model_inst.read(8'h13, 1);
    $display("Test identity done");
    rnd16(a1);
    conv(16'h0800, a1);
    chk("irq pin masked", 8'h00, {7'h00, irq_pin_oe});
    nopersist_irq_enable = 1'b1;
    wt(2);
    chk("irq pin enabled", 8'h01, {7'h00, irq_pin_oe});
    lsdr_host_model_inst.write(8'h13, 8'h3F);
    exp_q.push_back(8'h21);
    lsdr_host_model_inst.read(8'h13, 1);
    clear_irq();
    nopersist_irq_enable = 1'b0;
    persist_low_thr = 16'h1000;
    conv(16'h0800, a1);
    exp_q.push_back(8'h31);
    lsdr_host_model_inst.read(8'h13, 1);
    clear_irq();
    sensing_enable = 1'b0;
    wt(2);
    exp_q.push_back(8'h00);
    lsdr_host_model_inst.read(8'h13, 1);
    sensing_enable = 1'b1;
    $display("Test status done");
    persist_sel = 4'h2;
    light_irq_enable = 1'b1;
    nopersist_low_thr = 16'h0000;
    nopersist_high_thr = 16'hFFFF;
    clear_irq();
    conv(16'h0800, a1);
    chk("persist first", 8'h00, {7'h00, irq_pin_oe});
    conv(16'h2000, a1);
    conv(16'h0800, a1);
    chk("persist restart", 8'h00, {7'h00, irq_pin_oe});
    conv(16'h0800, a1);
    chk("persist second", 8'h01, {7'h00, irq_pin_oe});
    light_irq_enable = 1'b0;
    wt(2);
    chk("persist masked", 8'h00, {7'h00, irq_pin_oe});
    clear_irq();
    {persist_sel, light_irq_enable} = 5'h09;
    conv(16'h2000, a1);
    for (int i = 0; i < 5; i++) begin
      conv(16'h0800, a1);
      chk("persist five", {7'h00, (i == 4)}, {7'h00, irq_pin_oe});
    end
    persist_sel = 4'h0;
    clear_irq();
    conv(16'h2000, a1);
    chk("persist every", 8'h01, {7'h00, irq_pin_oe});
    light_irq_enable = 1'b0;
    clear_irq();
    $display("Test persistence done");
    rnd16(a0);
    rnd16(a1);
    conv(a0, a1);
    exp_q.push_back(a0[7:0]);
    lsdr_host_model_inst.read(8'h14, 1);
    rnd16(b0);
    rnd16(b1);
    conv(b0, b1);
    exp_q.push_back(b1[7:0]);
    lsdr_host_model_inst.read(8'h16, 1);
    exp_q.push_back(a0[15:8]);
    lsdr_host_model_inst.read(8'h15, 1);
    exp_q.push_back(b1[15:8]);
    lsdr_host_model_inst.read(8'h17, 1);
    rnd16(a0);
    conv(a0, b0);
    exp_q.push_back(a0[7:0]);
    exp_q.push_back(a0[15:8]);
    exp_q.push_back(b0[7:0]);
    exp_q.push_back(b0[15:8]);
    exp_q.push_back(8'h00);
    lsdr_host_model_inst.read(8'h14, 5);
    $display("Test data done");
    wt(4);
    chk("pending notes", 8'h00, 8'(exp_q.size()));
    chk("missing acks", 8'h00, nack_cnt[7:0]);
    chk("pin levels", 8'h00, {6'h00, sda_out, irq_pin_out});
    give_verdict();
  end
endmodule : lsdr_top_tb
